/* File: rtl/stcc_params.svh */
// constants of the 16-bit timer with compare, modulation and capture
`ifndef STCC_PARAMS_SVH
`define STCC_PARAMS_SVH
// ----------------------------------------
// register offsets on the io bus
// ----------------------------------------
`define STCC_ADDR_CAP_LO 6'h26
`define STCC_ADDR_CAP_HI 6'h27
`define STCC_ADDR_CMP_LO 6'h2a
`define STCC_ADDR_CMP_HI 6'h2b
`define STCC_ADDR_CNT_LO 6'h2c
`define STCC_ADDR_CNT_HI 6'h2d
`define STCC_ADDR_CTRL_B 6'h2e
`define STCC_ADDR_CTRL_A 6'h2f
// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define STCC_CTRL_A_MASK 8'hc3
`define STCC_CTRL_B_MASK 8'hcf
`define STCC_CTRL_RESET 8'h00
`define STCC_WORD_ZERO 16'h0000
`define STCC_WORD_ONES 16'hffff
`define STCC_TOP_8 16'h00ff
`define STCC_TOP_9 16'h01ff
`define STCC_TOP_10 16'h03ff
`define STCC_NC_SAMPLES 4
`endif

/* File: rtl/stcc_pkg.sv */
// types shared by the timer files
package stcc_pkg;
  typedef logic [7:0] stcc_byte_t;
  // clock source select codes
  typedef enum logic [2:0] {
    STCC_CS_STOP = 3'b000, STCC_CS_CLK = 3'b001, STCC_CS_D8 = 3'b010,
    STCC_CS_D64 = 3'b011, STCC_CS_D256 = 3'b100, STCC_CS_D1024 = 3'b101,
    STCC_CS_EXT_FALL = 3'b110, STCC_CS_EXT_RISE = 3'b111
  } stcc_cs_t;
  // modulation select codes
  typedef enum logic [1:0] {
    STCC_PWM_OFF = 2'b00, STCC_PWM_8 = 2'b01, STCC_PWM_9 = 2'b10, STCC_PWM_10 = 2'b11
  } stcc_pwm_t;
  // whole state of the timer except the capture filter
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] ocr;
    logic [15:0] ocr_act;
    logic [15:0] cap;
    logic [7:0] temp;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] rdata;
    logic dir_down;
    logic tick_d;
    logic ext_s1, ext_s2, ext_s3;
    logic icp_s1, icp_s2;
    logic aco_s1, aco_s2;
    logic oc_lvl;
    logic oc_oe_n;
    logic cap_flag, cmp_flag, ovf_flag;
  } stcc_state_t;
endpackage

/* File: rtl/stcc_capture_filter.sv */
// capture edge detector with optional sample-count noise filter
`include "stcc_params.svh"
module stcc_capture_filter #(
  parameter int SAMPLES = `STCC_NC_SAMPLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic sample,
  input wire logic edge_sel,
  input wire logic filter_en,
  output logic trig
);
  import stcc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [SAMPLES-1:0] hist; // newest sample in bit 0
    logic lvl;                // accepted input level
    logic trig;               // one-cycle capture request
  } stcc_filt_t;

  stcc_filt_t r, n;

  // next state: accept level, flag change toward chosen polarity
  always_comb begin
    n = r;
    n.hist = {r.hist[SAMPLES-2:0], sample};
    if (filter_en) begin
      // a glitch shorter than the window never moves the level
      if (&n.hist) begin
        n.lvl = 1'b1;
      end else if (~|n.hist) begin
        n.lvl = 1'b0;
      end
    end else begin
      n.lvl = sample;
    end
    n.trig = (n.lvl != r.lvl) && (n.lvl == edge_sel);
  end

  // register the state; ce freezes everything
  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign trig = r.trig;
endmodule

/* File: rtl/stcc_timer.sv */
// 16-bit timer/counter: compare, modulation, capture, io registers
`include "stcc_params.svh"
module stcc_timer (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output stcc_pkg::stcc_byte_t io_rdata,
  input wire logic [3:0] presc_tick,
  input wire logic external_count_pin,
  input wire logic capture_input_pin,
  input wire logic comparator_output,
  input wire logic capture_src_comparator,
  input wire logic compare_pin_dir,
  output logic compare_output_pin,
  output logic compare_output_pin_oe_n,
  output logic capture_flag,
  output logic compare_flag,
  output logic overflow_flag
);
  import stcc_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // pick the counting tick for a clock select code
  function automatic logic sel_tick(stcc_cs_t cs, logic [3:0] taps,
                                    logic rise, logic fall);
    logic t;
    t = 1'b0;
    unique case (cs)
      STCC_CS_STOP: t = 1'b0;
      STCC_CS_CLK: t = 1'b1;
      STCC_CS_D8: t = taps[0];
      STCC_CS_D64: t = taps[1];
      STCC_CS_D256: t = taps[2];
      STCC_CS_D1024: t = taps[3];
      STCC_CS_EXT_FALL: t = fall;
      STCC_CS_EXT_RISE: t = rise;
    endcase
    return t;
  endfunction

  // turning point of the up/down count
  function automatic logic [15:0] top_of(stcc_pwm_t m);
    logic [15:0] t;
    t = `STCC_TOP_10;
    unique case (m)
      STCC_PWM_OFF: t = `STCC_WORD_ONES;
      STCC_PWM_8: t = `STCC_TOP_8;
      STCC_PWM_9: t = `STCC_TOP_9;
      STCC_PWM_10: t = `STCC_TOP_10;
    endcase
    return t;
  endfunction

  // ----------------------------------------
  // state and decoded controls
  // ----------------------------------------
  stcc_state_t r, n;

  stcc_pwm_t pwm_mode;  // modulation select field
  stcc_cs_t clk_sel;    // clock select field
  logic [1:0] com;      // compare output mode
  logic ctc;            // clear on match enable
  logic edge_sel;       // capture edge select
  logic nc_en;          // capture noise filter enable
  logic pwm_on;         // any modulation mode
  logic [15:0] top;     // turning point in modulation
  logic tick;           // counter advances this cycle
  logic ext_rise;       // synced rising edge of count pin
  logic ext_fall;       // synced falling edge of count pin
  logic match;          // compare match detected this cycle
  logic cap_sample;     // selected capture source level
  logic cap_trig;       // capture request from filter
  logic [15:0] cnt_up;  // counter plus one
  logic [15:0] cnt_dn;  // counter minus one

  assign pwm_mode = stcc_pwm_t'(r.ctrl_a[1:0]);
  assign com = r.ctrl_a[7:6];
  assign nc_en = r.ctrl_b[7];
  assign edge_sel = r.ctrl_b[6];
  assign ctc = r.ctrl_b[3];
  assign clk_sel = stcc_cs_t'(r.ctrl_b[2:0]);
  assign pwm_on = (pwm_mode != STCC_PWM_OFF);
  assign top = top_of(pwm_mode);
  assign cnt_up = r.cnt + 16'h0001;
  assign cnt_dn = r.cnt - 16'h0001;

  // count pin is taken from the synced copy, never from the port
  // direction, so software driving the pin still counts
  assign ext_rise = r.ext_s2 & ~r.ext_s3;
  assign ext_fall = ~r.ext_s2 & r.ext_s3;
  assign tick = sel_tick(clk_sel, presc_tick, ext_rise, ext_fall);

  // the counter lands on a value at a tick, the match is seen one
  // clock later; with a slow tick the value therefore shows once
  assign match = r.tick_d &&
                 (r.cnt == (pwm_on ? (r.ocr_act & top) : r.ocr_act));

  // capture source: pin or comparator, both synced
  assign cap_sample = capture_src_comparator ? r.aco_s2 : r.icp_s2;

  // ----------------------------------------
  // capture edge detection
  // ----------------------------------------
  stcc_capture_filter #(
    .SAMPLES(`STCC_NC_SAMPLES)
  ) u_filter (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .sample(cap_sample),
    .edge_sel(edge_sel),
    .filter_en(nc_en),
    .trig(cap_trig)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = r;
    n.cap_flag = 1'b0;
    n.cmp_flag = 1'b0;
    n.ovf_flag = 1'b0;

    // two-stage synchronisers on the asynchronous pins
    n.ext_s1 = external_count_pin;
    n.ext_s2 = r.ext_s1;
    n.ext_s3 = r.ext_s2;
    n.icp_s1 = capture_input_pin;
    n.icp_s2 = r.icp_s1;
    n.aco_s1 = comparator_output;
    n.aco_s2 = r.aco_s1;
    n.tick_d = tick;

    // counting
    if (tick) begin
      if (pwm_on) begin
        // direction flips on arrival at an end point, so a match at
        // zero or top sees the direction of the coming slope
        if (!r.dir_down) begin
          n.cnt = cnt_up;
          if (cnt_up == top) begin
            n.dir_down = 1'b1;
            n.ocr_act = r.ocr;
          end
        end else begin
          n.cnt = cnt_dn;
          if (cnt_dn == `STCC_WORD_ZERO) begin
            n.dir_down = 1'b0;
            n.ovf_flag = 1'b1;
          end
        end
      end else begin
        n.cnt = cnt_up;
        n.dir_down = 1'b0;
        if (r.cnt == `STCC_WORD_ONES) begin
          n.ovf_flag = 1'b1;
        end
      end
    end

    // compare match: flag, clear and pin action
    if (match) begin
      n.cmp_flag = 1'b1;
      if (!pwm_on && ctc) begin
        n.cnt = `STCC_WORD_ZERO;
      end
      if (pwm_on) begin
        // 10 clears going up and sets going down; 11 is the inverse
        if (com == 2'b10) begin
          n.oc_lvl = r.dir_down;
        end else if (com == 2'b11) begin
          n.oc_lvl = ~r.dir_down;
        end
      end else begin
        unique case (com)
          2'b00: n.oc_lvl = r.oc_lvl;
          2'b01: n.oc_lvl = ~r.oc_lvl;
          2'b10: n.oc_lvl = 1'b0;
          2'b11: n.oc_lvl = 1'b1;
        endcase
      end
    end

    // pin is only released to the port when mode and direction agree
    n.oc_oe_n = ~(compare_pin_dir &&
                  (pwm_on ? com[1] : (com != 2'b00)));

    // capture copies the live counter and raises its flag together
    if (cap_trig) begin
      n.cap = r.cnt;
      n.cap_flag = 1'b1;
    end

    // register reads; capture and count low byte reads park the high byte in the latch
    if (io_rd) begin
      unique case (io_addr)
        `STCC_ADDR_CAP_LO: begin
          n.rdata = r.cap[7:0];
          n.temp = r.cap[15:8];
        end
        `STCC_ADDR_CAP_HI: n.rdata = r.temp;
        `STCC_ADDR_CMP_LO: n.rdata = r.ocr[7:0];
        `STCC_ADDR_CMP_HI: n.rdata = r.ocr[15:8];
        `STCC_ADDR_CNT_LO: begin
          n.rdata = r.cnt[7:0];
          n.temp = r.cnt[15:8];
        end
        `STCC_ADDR_CNT_HI: n.rdata = r.temp;
        `STCC_ADDR_CTRL_B: n.rdata = r.ctrl_b & `STCC_CTRL_B_MASK;
        `STCC_ADDR_CTRL_A: n.rdata = r.ctrl_a & `STCC_CTRL_A_MASK;
        default: n.rdata = 8'h00;
      endcase
    end

    // register writes; high bytes go only to the shared latch
    if (io_wr) begin
      unique case (io_addr)
        `STCC_ADDR_CMP_HI: n.temp = io_wdata;
        `STCC_ADDR_CMP_LO: n.ocr = {r.temp, io_wdata};
        `STCC_ADDR_CNT_HI: n.temp = io_wdata;
        `STCC_ADDR_CNT_LO: n.cnt = {r.temp, io_wdata};
        `STCC_ADDR_CTRL_B: n.ctrl_b = io_wdata & `STCC_CTRL_B_MASK;
        `STCC_ADDR_CTRL_A: n.ctrl_a = io_wdata & `STCC_CTRL_A_MASK;
        default: n.temp = n.temp; // capture and unmapped: ignored
      endcase
    end

    // outside modulation the comparator uses the written value at once
    if (!pwm_on) begin
      n.ocr_act = n.ocr;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------

  // synchronous reset; ce low holds every bit of state
  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
      r.oc_oe_n <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign io_rdata = r.rdata;
  assign compare_output_pin = r.oc_lvl;
  assign compare_output_pin_oe_n = r.oc_oe_n;
  assign capture_flag = r.cap_flag;
  assign compare_flag = r.cmp_flag;
  assign overflow_flag = r.ovf_flag;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // capture request: flag and copy appear together one clock later
  sequence s_cap_req;
    ce && cap_trig;
  endsequence
  sequence s_cap_done(logic [15:0] v);
    capture_flag && (r.cap == v);
  endsequence
  property p_cap_copy;
    logic [15:0] v;
    (s_cap_req, v = r.cnt) |=> s_cap_done(v);
  endproperty
  a_cap_copy: assert property (p_cap_copy) else $error("capture copy or flag wrong");

  property p_ctc_clear;
    ce && match && ctc && !pwm_on && !(io_wr && io_addr == `STCC_ADDR_CNT_LO)
      |=> r.cnt == `STCC_WORD_ZERO;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("counter not cleared on match");

  property p_pwm_no_clear;
    ce && match && pwm_on && r.tick_d && tick && !r.dir_down && (cnt_up != top) && !io_wr
      |=> r.cnt == $past(cnt_up);
  endproperty
  a_pwm_no_clear: assert property (p_pwm_no_clear) else $error("clear acted in modulation");

  property p_reserved_a;
    ce && io_rd && io_addr == `STCC_ADDR_CTRL_A |=> io_rdata[5:2] == 4'h0;
  endproperty
  a_reserved_a: assert property (p_reserved_a) else $error("reserved bits not zero");

  property p_pin_gate;
    ce && !compare_pin_dir |=> compare_output_pin_oe_n;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin driven while input");

  property p_toggle;
    ce && match && !pwm_on && com == 2'b01 |=> compare_output_pin != $past(compare_output_pin);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle mode did not toggle");

  property p_load;
    ce && io_wr && io_addr == `STCC_ADDR_CNT_LO |=> r.cnt == {$past(r.temp), $past(io_wdata)};
  endproperty
  a_load: assert property (p_load) else $error("16-bit load wrong");

  property p_read_latch;
    ce && io_rd && io_addr == `STCC_ADDR_CNT_LO && !io_wr
      |=> r.temp == $past(r.cnt[15:8]) && io_rdata == $past(r.cnt[7:0]);
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("low read did not latch high");

  property p_stopped;
    ce && clk_sel == STCC_CS_STOP && !r.tick_d && !io_wr |=> $stable(r.cnt);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter moved");

  property p_pwm_turn;
    ce && pwm_on && tick && !r.dir_down && cnt_up == top && !io_wr |=> r.dir_down && r.cnt == $past(top);
  endproperty
  a_pwm_turn: assert property (p_pwm_turn) else $error("no turn at top");
endmodule

/* File: bench/stcc_cpu_model.sv */
// cpu-side model that drives the timer io register bus
module stcc_cpu_model (
  input wire logic clock,
  output logic [5:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire stcc_pkg::stcc_byte_t io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import stcc_pkg::*;
  // ----------------------------------------
  // bus idle state
  // ----------------------------------------
  initial begin
    io_addr = 6'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // one write; strobe spans exactly one rising edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clock);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clock);
    io_wr = 1'b0;
    // released lines show a changed value, never the stale one
    io_addr = ~a;
    io_wdata = ~d;
  endtask
  // one read; data taken half a cycle after the read edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clock);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clock);
    io_rd = 1'b0;
    d = io_rdata;
    io_addr = ~a;
  endtask
  // high byte first, so the shared latch holds it when low lands
  task automatic wr16(input logic [5:0] a, input logic [15:0] v);
    wr(a + 6'h1, v[15:8]);
    wr(a, v[7:0]);
  endtask
  // low byte first; calls run one at a time, so no access splits a pair
  task automatic rd16(input logic [5:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 6'h1, v[15:8]);
  endtask
endmodule

/* File: bench/stcc_timer_tb_top.sv */
// self-checking bench for the 16-bit timer through its io registers
`include "stcc_params.svh"
module stcc_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import stcc_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] presc_tick = 4'h0; // prescaler tap pulses
  logic ext_pin = 1'b0;
  logic cap_pin = 1'b0;
  logic cmp_out = 1'b0;
  logic src_cmp = 1'b0;
  logic pin_dir = 1'b0;
  logic [5:0] io_addr;
  logic io_wr, io_rd;
  logic [7:0] io_wdata;
  stcc_byte_t io_rdata;
  logic oc_pin, oc_oe_n, cap_f, cmp_f, ovf_f;
  int n_errors = 0;
  int n_checks = 0;
  int n;
  logic [7:0] b;
  logic [15:0] v;
  // 20 MHz clock
  always #25 clock = ~clock;
  stcc_cpu_model cpu_u (.clock(clock), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata));
  // ce tied high: freezing is not exercised here
  stcc_timer dut_u (.clock(clock), .rst(rst), .ce(1'b1), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .presc_tick(presc_tick),
    .external_count_pin(ext_pin), .capture_input_pin(cap_pin), .comparator_output(cmp_out),
    .capture_src_comparator(src_cmp), .compare_pin_dir(pin_dir), .compare_output_pin(oc_pin),
    .compare_output_pin_oe_n(oc_oe_n), .capture_flag(cap_f), .compare_flag(cmp_f),
    .overflow_flag(ovf_f));
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // wait for a flag pulse (0 compare, 1 overflow, 2 capture), bounded
  task automatic wf(input int sel, input int lim, output int k);
    logic f;
    k = 0;
    f = 1'b0;
    while (!f) begin
      @(negedge clock);
      k++;
      f = (sel == 0) ? cmp_f === 1'b1 : (sel == 1) ? ovf_f === 1'b1 : cap_f === 1'b1;
      if (!f && k >= lim) begin
        n_errors++;
        $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        report_and_stop();
      end
    end
  endtask
  // no capture may fire for k cycles
  task automatic nf(input int k);
    repeat (k) begin
      @(negedge clock);
      chk(16'(cap_f), 16'h0000);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge clock);
    rst = 1'b0;
    // all rw registers clear after reset
    for (int a = 42; a < 48; a++) begin
      cpu_u.rd(6'(a), b);
      chk(16'(b), 16'h0000);
    end
    // reserved control bits stay zero
    cpu_u.wr(`STCC_ADDR_CTRL_A, 8'hff);
    cpu_u.rd(`STCC_ADDR_CTRL_A, b);
    chk(16'(b), 16'h00c3);
    cpu_u.wr(`STCC_ADDR_CTRL_A, 8'h00);
    cpu_u.wr(`STCC_ADDR_CTRL_B, 8'hf0);
    cpu_u.rd(`STCC_ADDR_CTRL_B, b);
    chk(16'(b), 16'h00c0);
    cpu_u.wr(`STCC_ADDR_CTRL_B, 8'h00);
    $display("test control registers done");
    // shared latch: a capture-high read shows the latched count high byte
    cpu_u.wr16(`STCC_ADDR_CNT_LO, 16'h1234);
    cpu_u.rd(`STCC_ADDR_CNT_LO, b);
    chk(16'(b), 16'h0034);
    cpu_u.rd(`STCC_ADDR_CAP_HI, b);
    chk(16'(b), 16'h0012);
    cpu_u.rd(`STCC_ADDR_CNT_HI, b);
    chk(16'(b), 16'h0012);
    cpu_u.wr(`STCC_ADDR_CAP_LO, 8'h55);
    cpu_u.rd(`STCC_ADDR_CAP_LO, b);
    chk(16'(b), 16'h0000);
    cpu_u.rd(6'h30, b);
    chk(16'(b), 16'h0000);
    $display("test byte latch done");
    // every clock source except the undivided clock; the pin pulses with the selected tap, and all four taps pulse for the stop and pin codes
    pin_dir = 1'b1;
    for (int c = 0; c < 8; c++) begin
      if (c != 1) begin
        cpu_u.wr16(`STCC_ADDR_CNT_LO, 16'h0000);
        cpu_u.wr(`STCC_ADDR_CTRL_B, 8'(c));
        repeat (4) begin
          @(negedge clock);
          presc_tick = (c >= 2 && c <= 5) ? 4'(1 << (c - 2)) : 4'hf;
          ext_pin = 1'b1;
          @(negedge clock);
          presc_tick = 4'h0;
          repeat (4) @(negedge clock);
          ext_pin = 1'b0;
          repeat (4) @(negedge clock);
        end
        cpu_u.wr(`STCC_ADDR_CTRL_B, 8'h00);
        cpu_u.rd16(`STCC_ADDR_CNT_LO, v);
        chk(v, (c == 0) ? 16'h0000 : 16'h0004);
      end
    end
    $display("test clock select done");
    // clear on match at 5: counter runs 0..5, so matches come 6 apart
    cpu_u.wr16(`STCC_ADDR_CMP_LO, 16'h0005);
    cpu_u.wr(`STCC_ADDR_CTRL_B, 8'h09);
    wf(0, 20, n);
    wf(0, 20, n);
    chk(16'(n), 16'h0006);
    // pin actions: set, clear, toggle, off
    for (int m = 3; m >= 0; m--) begin
      cpu_u.wr(`STCC_ADDR_CTRL_A, 8'(m << 6));
      wf(0, 20, n);
      chk(16'(oc_oe_n), 16'(m == 0));
      if (m != 0) begin
        chk(16'(oc_pin), 16'(m != 2));
      end
      if (m == 1) begin
        wf(0, 20, n);
        chk(16'(oc_pin), 16'h0000);
      end
    end
    // direction bit low keeps the pin undriven
    cpu_u.wr(`STCC_ADDR_CTRL_A, 8'hc0);
    pin_dir = 1'b0;
    wf(0, 20, n);
    chk(16'(oc_oe_n), 16'h0001);
    // wrap from all ones, no clear
    cpu_u.wr(`STCC_ADDR_CTRL_B, 8'h01);
    cpu_u.wr16(`STCC_ADDR_CNT_LO, 16'hfff0);
    wf(1, 40, n);
    chk(16'(n >= 14 && n <= 20), 16'h0001);
    $display("test compare done");
    // capture on rising pin, filter off
    cpu_u.wr(`STCC_ADDR_CTRL_B, 8'h00);
    cpu_u.wr16(`STCC_ADDR_CNT_LO, 16'h0abc);
    cpu_u.wr(`STCC_ADDR_CTRL_B, 8'h40);
    @(negedge clock);
    cap_pin = 1'b1;
    wf(2, 8, n);
    cpu_u.rd16(`STCC_ADDR_CAP_LO, v);
    chk(v, 16'h0abc);
    // filter on, falling: a two-cycle dip is ignored, a held low is not
    cpu_u.wr16(`STCC_ADDR_CNT_LO, 16'h1357);
    cpu_u.wr(`STCC_ADDR_CTRL_B, 8'h80);
    @(negedge clock);
    cap_pin = 1'b0;
    repeat (2) @(negedge clock);
    cap_pin = 1'b1;
    nf(12);
    cap_pin = 1'b0;
    wf(2, 12, n);
    chk(16'(n >= 6), 16'h0001);
    cpu_u.rd16(`STCC_ADDR_CAP_LO, v);
    chk(v, 16'h1357);
    // comparator as source: the pin is ignored
    cpu_u.wr16(`STCC_ADDR_CNT_LO, 16'h2468);
    cpu_u.wr(`STCC_ADDR_CTRL_B, 8'h40);
    src_cmp = 1'b1;
    cap_pin = 1'b1;
    nf(8);
    cmp_out = 1'b1;
    wf(2, 8, n);
    cpu_u.rd16(`STCC_ADDR_CAP_LO, v);
    chk(v, 16'h2468);
    $display("test capture done");
    // modulation: up/down period per resolution, clear on match ignored
    cpu_u.wr16(`STCC_ADDR_CMP_LO, 16'h0003);
    cpu_u.wr16(`STCC_ADDR_CNT_LO, 16'h0000);
    cpu_u.wr(`STCC_ADDR_CTRL_B, 8'h09);
    for (int p = 1; p < 4; p++) begin
      cpu_u.wr(`STCC_ADDR_CTRL_A, 8'(8'h80 | p));
      wf(1, 4200, n);
      wf(1, 4200, n);
      chk(16'(n), 16'((512 << (p - 1)) - 2));
    end
    // mode 10: down-count match at 3 sets the pin, up-count match clears it
    pin_dir = 1'b1;
    wf(1, 4200, n);
    chk(16'(oc_pin), 16'h0001);
    repeat (5) @(negedge clock);
    chk(16'(oc_pin), 16'h0000);
    chk(16'(oc_oe_n), 16'h0000);
    cpu_u.wr16(`STCC_ADDR_CMP_LO, 16'h0155);
    cpu_u.rd16(`STCC_ADDR_CMP_LO, v);
    chk(v, 16'h0155);
    $display("test modulation done");
    report_and_stop();
  end
endmodule
